// *** iep_pkg.sv ***
// shared constants for the capture/serial enable and ext1 priority slice
package iep_pkg;

    // register byte offsets on the apb window
    localparam logic [11:0] OFS_ENABLE = 12'h000;
    localparam logic [11:0] OFS_PRIO   = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_MASK   = 12'h00c;

    // enable register field positions
    localparam int BIT_CAP4  = 6;
    localparam int BIT_CAP3  = 5;
    localparam int BIT_S2EVT = 1;
    localparam int BIT_S2FLT = 0;

    // implemented enable bits and reset values
    localparam logic [15:0] ENABLE_IMPL = 16'h0063;
    localparam logic [15:0] ENABLE_RST  = 16'h0000;

    // priority field
    localparam int          PRIO_W   = 3;
    localparam logic [2:0]  PRIO_RST = 3'h4;
    localparam logic [2:0]  PRIO_OFF = 3'h0;

    // request lanes, also the status and mask bit positions
    localparam int EV_CAP4  = 0;
    localparam int EV_CAP3  = 1;
    localparam int EV_S2EVT = 2;
    localparam int EV_S2FLT = 3;
    localparam int EV_EXT1  = 4;
    localparam int NUM_SRC  = 5;

    localparam logic [4:0] STATUS_RST = 5'h00;
    localparam logic [4:0] MASK_RST   = 5'h00;

    // exact 12-bit address match inside the 4 KiB window
    function automatic logic reg_hit(input logic [11:0] addr,
                                     input logic [11:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

endpackage

// *** iep_apb_port.sv ***
// apb slave handshake: read data capture, ready and error answer
`timescale 1ns/1ps
module iep_apb_port
    import iep_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic        hit_i,
    input  wire logic [31:0] rd_word_i,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic [31:0]      prdata_o,
    output logic             wr_stb_o
);

    logic       armed;
    logic       miss;
    wire  logic setup_w = psel_i & ~penable_i;
    wire  logic done_w  = psel_i & penable_i & pready_o;

    // answer only once the setup cycle has been seen under clock enable
    assign pready_o  = armed & ce_i;
    assign pslverr_o = pready_o & miss;
    assign wr_stb_o  = done_w & pwrite_i & ~miss;

    // read data is sampled in setup so prdata comes from a flop
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed    <= 1'b0;
            miss     <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            if (setup_w) begin
                armed    <= 1'b1;
                miss     <= ~hit_i;
                prdata_o <= (hit_i && !pwrite_i) ? rd_word_i : 32'h0;
            end else if (done_w) begin
                armed <= 1'b0;
            end
        end
    end

endmodule

// *** iep_req_gate.sv ***
// per-lane request gate with registered output and rising-edge event
`timescale 1ns/1ps
module iep_req_gate #(
    parameter int N = 5
) (
    input  wire logic         core_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    input  wire logic [N-1:0] req_i,
    input  wire logic [N-1:0] en_i,
    output logic      [N-1:0] gnt_o,
    output logic      [N-1:0] evt_o
);

    // a zero-lane gate has nothing to drive
    if (N < 1) begin : g_bad_width
        $error("iep_req_gate needs at least one lane");
    end

    wire logic [N-1:0] next_gnt = req_i & en_i;

    // event fires once per new gated request, not every held cycle
    assign evt_o = next_gnt & ~gnt_o & {N{ce_i}};

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gnt_o <= '0;
        end else if (ce_i) begin
            gnt_o <= next_gnt;
        end
    end

endmodule

// *** iep_top.sv ***
// interrupt enable slice and external interrupt 1 priority register
`timescale 1ns/1ps
// Contract
// - capture 4 request passes only when enabled
// - capture 3 enable bit, read/write, gates request
// - enable bits 4..2 read zero, ignore writes
// - serial 2 event request gated by bit 1
// - priority register: only bits 2..0 implemented
// - priority field resets to binary 100
// - priority 7 highest, 000 disables ext1
module iep_top
    import iep_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic [31:0]      prdata_o,
    input  wire logic        capture4_req_i,
    input  wire logic        capture3_req_i,
    input  wire logic        serial2_event_req_i,
    input  wire logic        serial2_fault_req_i,
    input  wire logic        ext1_req_i,
    output logic             capture4_irq_o,
    output logic             capture3_irq_o,
    output logic             serial2_event_irq_o,
    output logic             serial2_fault_irq_o,
    output logic             ext1_irq_o,
    output logic [2:0]       ext1_priority_level_o,
    output logic             irq_o
);

    // registers
    logic [15:0] capture_spi_interrupt_enables;
    logic [15:0] external_int1_priority;
    logic [4:0]  irq_status;
    logic [4:0]  irq_mask;

    // bus decode
    wire logic hit_enable = reg_hit(paddr_i, OFS_ENABLE);
    wire logic hit_prio   = reg_hit(paddr_i, OFS_PRIO);
    wire logic hit_status = reg_hit(paddr_i, OFS_STATUS);
    wire logic hit_mask   = reg_hit(paddr_i, OFS_MASK);
    wire logic hit_any    = hit_enable | hit_prio | hit_status | hit_mask;
    wire logic wr_stb;

    // write strobes per register
    wire logic wr_enable = wr_stb & hit_enable;
    wire logic wr_prio   = wr_stb & hit_prio;
    wire logic wr_status = wr_stb & hit_status;
    wire logic wr_mask   = wr_stb & hit_mask;

    // readback mux, unimplemented bits forced low by the stored masks
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_enable) begin
            rd_word[15:0] = capture_spi_interrupt_enables;
        end else if (hit_prio) begin
            rd_word[15:0] = external_int1_priority;
        end else if (hit_status) begin
            rd_word[4:0] = irq_status;
        end else if (hit_mask) begin
            rd_word[4:0] = irq_mask;
        end
    end

    iep_apb_port u_apb (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .psel_i     (psel_i),
        .penable_i  (penable_i),
        .pwrite_i   (pwrite_i),
        .hit_i      (hit_any),
        .rd_word_i  (rd_word),
        .pready_o   (pready_o),
        .pslverr_o  (pslverr_o),
        .prdata_o   (prdata_o),
        .wr_stb_o   (wr_stb)
    );

    // field views of the stored registers
    wire logic [2:0] prio_level = external_int1_priority[PRIO_W-1:0];
    wire logic ext1_on = (prio_level != PRIO_OFF);

    // per-lane request and enable vectors
    wire logic [NUM_SRC-1:0] req_vec = {ext1_req_i,
                                        serial2_fault_req_i,
                                        serial2_event_req_i,
                                        capture3_req_i,
                                        capture4_req_i};
    wire logic [NUM_SRC-1:0] en_vec = {
        ext1_on,
        capture_spi_interrupt_enables[BIT_S2FLT],
        capture_spi_interrupt_enables[BIT_S2EVT],
        capture_spi_interrupt_enables[BIT_CAP3],
        capture_spi_interrupt_enables[BIT_CAP4]};
    wire logic [NUM_SRC-1:0] gnt_vec;
    wire logic [NUM_SRC-1:0] evt_vec;

    // gating is registered so the core sees glitch-free requests
    iep_req_gate #(
        .N (NUM_SRC)
    ) u_gate (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .req_i      (req_vec),
        .en_i       (en_vec),
        .gnt_o      (gnt_vec),
        .evt_o      (evt_vec)
    );

    // gated requests toward the core
    assign capture4_irq_o        = gnt_vec[EV_CAP4];
    assign capture3_irq_o        = gnt_vec[EV_CAP3];
    assign serial2_event_irq_o   = gnt_vec[EV_S2EVT];
    assign serial2_fault_irq_o   = gnt_vec[EV_S2FLT];
    assign ext1_irq_o            = gnt_vec[EV_EXT1];
    assign ext1_priority_level_o = prio_level;
    assign irq_o                 = |(irq_status & irq_mask);

    // next values; sticky set beats a same-cycle write-one clear
    wire logic [15:0] next_enable = pwdata_i[15:0] & ENABLE_IMPL;
    wire logic [15:0] next_prio = {13'h0000, pwdata_i[2:0]};
    wire logic [4:0] clr_status = wr_status ? pwdata_i[4:0] : 5'h00;
    wire logic [4:0] next_status = (irq_status & ~clr_status) | evt_vec;

    // configuration registers
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            capture_spi_interrupt_enables <= ENABLE_RST;
            external_int1_priority <= {13'h0000, PRIO_RST};
            irq_mask <= MASK_RST;
        end else if (ce_i) begin
            if (wr_enable) begin
                capture_spi_interrupt_enables <= next_enable;
            end
            if (wr_prio) begin
                external_int1_priority <= next_prio;
            end
            if (wr_mask) begin
                irq_mask <= pwdata_i[4:0];
            end
        end
    end

    // sticky status, frozen with the rest when clock enable is low
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_status <= STATUS_RST;
        end else if (ce_i) begin
            irq_status <= next_status;
        end
    end

    // checks, all on the core clock
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // completed read of a given register
    wire logic rd_done = psel_i & penable_i & pready_o & ~pwrite_i;
    logic      rd_was_enable;
    logic      rd_was_prio;
    logic      first_cycle;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_was_enable <= 1'b0;
            rd_was_prio   <= 1'b0;
            first_cycle   <= 1'b1;
        end else begin
            rd_was_enable <= rd_done & hit_enable;
            rd_was_prio   <= rd_done & hit_prio;
            first_cycle   <= 1'b0;
        end
    end

    sequence s_cap4_off;
        ce_i && !capture_spi_interrupt_enables[BIT_CAP4];
    endsequence

    sequence s_setup_then_access;
        psel_i && !penable_i && ce_i ##1 psel_i && penable_i;
    endsequence

    AST_CAP4_BLOCKED: assert property (
        s_cap4_off |=> !capture4_irq_o)
        else $error("capture 4 request passed while disabled");

    AST_CAP4_PASSED: assert property (
        ce_i && capture4_req_i && capture_spi_interrupt_enables[BIT_CAP4]
        |=> capture4_irq_o)
        else $error("capture 4 request lost while enabled");

    AST_CAP3_GATE: assert property (
        ce_i |=> capture3_irq_o == $past(capture3_req_i
            && capture_spi_interrupt_enables[BIT_CAP3]))
        else $error("capture 3 gate mismatch");

    AST_ENABLE_RSVD_ZERO: assert property (
        rd_was_enable |-> prdata_o[4:2] == 3'h0
            && prdata_o[31:16] == 16'h0000)
        else $error("unimplemented enable bits read nonzero");

    AST_S2EVT_GATE: assert property (
        ce_i && serial2_event_req_i
        |=> serial2_event_irq_o
            == $past(capture_spi_interrupt_enables[BIT_S2EVT]))
        else $error("serial 2 event gate mismatch");

    AST_S2FLT_GATE: assert property (
        ce_i && !capture_spi_interrupt_enables[BIT_S2FLT]
        |=> !serial2_fault_irq_o)
        else $error("serial 2 fault passed while disabled");

    AST_PRIO_RSVD_ZERO: assert property (
        rd_was_prio |-> prdata_o[31:3] == 29'h0)
        else $error("unimplemented priority bits read nonzero");

    AST_PRIO_WRITE: assert property (
        s_setup_then_access ##0 pready_o && pwrite_i && hit_prio
        |=> prio_level == $past(pwdata_i[2:0]))
        else $error("priority write not taken");

    AST_PRIO_RESET: assert property (
        first_cycle |-> prio_level == 3'h4)
        else $error("priority field reset value wrong");

    AST_EXT1_OFF: assert property (
        ce_i && prio_level == 3'h0 |=> !ext1_irq_o [*1])
        else $error("ext1 passed with priority 000");

    AST_IRQ_LEVEL: assert property (
        ce_i && (evt_vec & irq_mask) != 5'h00 |=> irq_o)
        else $error("unmasked event did not raise interrupt");

    // a write that completes this cycle; strobe timing mirrors the port
    sequence s_write_done;
        ce_i && psel_i && penable_i && pready_o && pwrite_i;
    endsequence

    // only the four enable bits can be written
    AST_ENABLE_WRITE: assert property (
        s_write_done ##0 hit_enable
        |=> capture_spi_interrupt_enables
            == ($past(pwdata_i[15:0]) & ENABLE_IMPL))
        else $error("enable write not masked to implemented bits");

    // unmapped writes must leave every register alone
    AST_MISS_NO_WRITE: assert property (
        s_write_done ##0 !hit_any
        |=> $stable(capture_spi_interrupt_enables)
            && $stable(external_int1_priority)
            && $stable(irq_mask))
        else $error("unmapped write changed a register");

    // error answer only for addresses outside the map
    AST_ERR_ON_MISS: assert property (
        ce_i && psel_i && penable_i && pready_o |-> pslverr_o == !hit_any)
        else $error("error answer disagrees with address decode");

    // upper priority bits are tied off at the register
    AST_PRIO_UPPER_ZERO: assert property (
        external_int1_priority[15:3] == 13'h0000)
        else $error("priority upper bits hold a one");

    // pass side of the fault gate, the block side is above
    AST_S2FLT_PASSED: assert property (
        ce_i && serial2_fault_req_i
        && capture_spi_interrupt_enables[BIT_S2FLT]
        |=> serial2_fault_irq_o)
        else $error("serial 2 fault request lost while enabled");

    AST_EXT1_ON: assert property (
        ce_i && ext1_req_i && prio_level != PRIO_OFF |=> ext1_irq_o)
        else $error("ext1 request lost with nonzero priority");

    // a same-cycle clear must not swallow a fresh event
    AST_SET_WINS: assert property (
        ce_i && evt_vec != 5'h00
        |=> (irq_status & $past(evt_vec)) == $past(evt_vec))
        else $error("status event lost against a clear");

    // clock enable low freezes state and holds the bus answer off
    AST_READY_FROZEN: assert property (
        !ce_i |-> !pready_o)
        else $error("ready raised while clock enable low");

    AST_STATE_FROZEN: assert property (
        !ce_i |=> $stable(capture_spi_interrupt_enables)
            && $stable(irq_status) && $stable(gnt_vec))
        else $error("state moved while clock enable low");

endmodule

// *** iep_core_model.sv ***
// behavioural core side: latches the gated request lines each cycle
`timescale 1ns/1ps
module iep_core_model (
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [4:0] irq_lines_i,
    input  wire logic [2:0] level_i,
    input  wire logic       irq_i,
    output logic      [4:0] taken_o,
    output logic      [2:0] level_o
);
    // the core samples requests like any same-clock flop would
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            taken_o <= 5'h00;
            level_o <= 3'h0;
        end else begin
            taken_o <= irq_lines_i;
            level_o <= irq_i ? level_i : 3'h0;
        end
    end
endmodule

// *** testbench.sv ***
// self-checking bench for the enable slice and ext1 priority register
`timescale 1ns/1ps
module testbench;
    import iep_pkg::*;
    logic        clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [4:0]  req, irqv, taken;
    logic [2:0]  lvl, core_lvl;
    int          fails, total_checks;
    int          bits [4] = '{BIT_CAP4, BIT_CAP3, BIT_S2EVT, BIT_S2FLT};
    int          lanes [4] = '{EV_CAP4, EV_CAP3, EV_S2EVT, EV_S2FLT};

    iep_top u_iep_top (.core_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
        .pslverr_o(pslverr), .prdata_o(prdata),
        .capture4_req_i(req[EV_CAP4]), .capture3_req_i(req[EV_CAP3]),
        .serial2_event_req_i(req[EV_S2EVT]),
        .serial2_fault_req_i(req[EV_S2FLT]), .ext1_req_i(req[EV_EXT1]),
        .capture4_irq_o(irqv[EV_CAP4]), .capture3_irq_o(irqv[EV_CAP3]),
        .serial2_event_irq_o(irqv[EV_S2EVT]),
        .serial2_fault_irq_o(irqv[EV_S2FLT]), .ext1_irq_o(irqv[EV_EXT1]),
        .ext1_priority_level_o(lvl), .irq_o(irq));

    iep_core_model u_iep_core_model (.core_clk_i(clk), .rst_n_i(rst_n),
        .irq_lines_i(irqv), .level_i(lvl), .irq_i(irq), .taken_o(taken),
        .level_o(core_lvl));

    // clock generator, 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; an idle edge first keeps drives one per step
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // answer read right at the edge, before its own updates land
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask

    // registered outputs land one edge late, the core model one more
    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic complete_run();
        if (fails == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog well past the 150 or so cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end

    initial begin
        fails = 0;
        total_checks = 0;
        rst_n = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        ce = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        req = 5'h00;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({29'h0, lvl}, {29'h0, PRIO_RST});
        rd(OFS_PRIO, 32'h4, 1'b0);
        rd(OFS_ENABLE, 32'h0, 1'b0);
        wr(OFS_ENABLE, 32'h0000_001c);
        rd(OFS_ENABLE, 32'h0, 1'b0);
        wr(OFS_ENABLE, 32'hffff_ffff);
        rd(OFS_ENABLE, 32'h63, 1'b0);
        wr(OFS_PRIO, 32'hffff_fffb);
        rd(OFS_PRIO, 32'h3, 1'b0);
        wr(OFS_PRIO, 32'hffff_ffff);
        rd(OFS_PRIO, 32'h7, 1'b0);
        // one enable bit at a time against all requests held high
        req <= 5'h1f;
        wr(OFS_ENABLE, 32'h0);
        settle();
        chk({27'h0, taken & 5'h0f}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_ENABLE, 32'h1 << bits[i]);
            settle();
            chk({27'h0, taken & 5'h0f}, 32'h1 << lanes[i]);
        end
        // clock enable low holds the gated lines despite a dropped request
        @(posedge clk);
        ce <= 1'b0;
        req <= 5'h00;
        settle();
        chk({27'h0, taken & 5'h0f}, 32'h8);
        @(posedge clk);
        ce <= 1'b1;
        settle();
        chk({27'h0, taken & 5'h0f}, 32'h0);
        @(posedge clk);
        req <= 5'h1f;
        // priority zero turns the ext1 source off
        wr(OFS_PRIO, 32'h0);
        settle();
        chk({31'h0, irqv[EV_EXT1]}, 32'h0);
        wr(OFS_PRIO, 32'h1);
        settle();
        chk({31'h0, irqv[EV_EXT1]}, 32'h1);
        chk({29'h0, lvl}, 32'h1);
        // status, mask, write-one-to-clear and an unmapped address
        @(posedge clk);
        req <= 5'h00;
        wr(OFS_ENABLE, 32'h63);
        wr(OFS_STATUS, 32'h1f);
        req <= 5'h1f;
        settle();
        rd(OFS_STATUS, 32'h1f, 1'b0);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_MASK, 32'h04);
        settle();
        chk({31'h0, irq}, 32'h1);
        chk({29'h0, core_lvl}, 32'h1);
        wr(OFS_STATUS, 32'h1f);
        settle();
        rd(OFS_STATUS, 32'h0, 1'b0);
        chk({31'h0, irq}, 32'h0);
        wr(12'h010, 32'hffff_ffff);
        rd(12'h010, 32'h0, 1'b1);
        rd(OFS_MASK, 32'h04, 1'b0);
        complete_run();
    end
endmodule
